// >>> design/fdhc_pkg.sv
// Package for the floppy drive host controller: timing constants and enums.
// Assumes a 125 MHz ref_clk; all times are converted to cycle counts here.
package fdhc_pkg;
   // ----------------------------------------------------------------------
   // Clock
   // ----------------------------------------------------------------------
   localparam int unsigned CLK_MHZ         = 125;
   // ----------------------------------------------------------------------
   // Times in their own units
   // ----------------------------------------------------------------------
   localparam int unsigned POWERON_MS      = 200;
   localparam int unsigned SPIN_FRESH_MS   = 700;
   localparam int unsigned SPIN_KEPT_MS    = 500;
   localparam int unsigned STEP_LOW_NS     = 800;   // Step pulse width
   localparam int unsigned DIR_SETUP_NS    = 1000;  // Direction before step
   localparam int unsigned STEP_RATE_MS    = 3;     // Track to track
   localparam int unsigned SETTLE_MS       = 15;
   localparam int unsigned WDATA_LOW_NS    = 200;   // Record pulse width
   // ----------------------------------------------------------------------
   // Derived cycle counts (least times rounded up)
   // ----------------------------------------------------------------------
   localparam int unsigned POWERON_CYC     = POWERON_MS * CLK_MHZ * 1000;
   localparam int unsigned SPIN_FRESH_CYC  = SPIN_FRESH_MS * CLK_MHZ * 1000;
   localparam int unsigned SPIN_KEPT_CYC   = SPIN_KEPT_MS * CLK_MHZ * 1000;
   localparam int unsigned STEP_LOW_CYC    = (STEP_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DIR_SETUP_CYC   = (DIR_SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned STEP_RATE_CYC   = STEP_RATE_MS * CLK_MHZ * 1000;
   localparam int unsigned SETTLE_CYC      = SETTLE_MS * CLK_MHZ * 1000;
   localparam int unsigned WDATA_LOW_CYC   = (WDATA_LOW_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned CNT_W           = 32;
   localparam int unsigned MAX_TRACKS      = 80;
   // ----------------------------------------------------------------------
   // Controller states, one-hot
   // ----------------------------------------------------------------------
   typedef enum logic [6:0] {
      FDHC_POR    = 7'h01,
      FDHC_IDLE   = 7'h02,
      FDHC_SETUP  = 7'h04,
      FDHC_PULSE  = 7'h08,
      FDHC_GAP    = 7'h10,
      FDHC_SETTLE = 7'h20,
      FDHC_SPINUP = 7'h40
   } fdhc_state_t;
endpackage

// >>> design/fdhc_sync.sv
// Two-flop synchroniser for the five drive outputs.
// Assumes the drive pins are asynchronous and idle high.
`timescale 1ns/10ps
`default_nettype none
module fdhc_sync
   import fdhc_pkg::*;
(
   input  wire logic   ref_clk,
   input  wire logic   rst_n,
   input  wire logic   clk_en,
   input  wire logic   [4:0] pins_n,
   fdhc_sync_if.src    so
);
   logic [4:0] meta;
   logic [4:0] stable;
   logic [4:0] next_meta;
   logic [4:0] next_stable;

   // ----------------------------------------------------------------------
   // Synchroniser
   // ----------------------------------------------------------------------
   // Stage one feeds only stage two
   always_comb begin
      next_meta   = clk_en ? pins_n : meta;
      next_stable = clk_en ? meta : stable;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         meta   <= 5'h1f;
         stable <= 5'h1f;
      end else begin
         meta   <= next_meta;
         stable <= next_stable;
      end
   end

   assign so.index_n = stable[0];
   assign so.trk0_n  = stable[1];
   assign so.wprot_n = stable[2];
   assign so.rdata_n = stable[3];
   assign so.chg_n   = stable[4];
endmodule // fdhc_sync
`default_nettype wire

// >>> design/fdhc_sync_if.sv
// Interface carrying synchronised drive status from the input stage.
// Assumes both ends share ref_clk.
`timescale 1ns/10ps
`default_nettype none
interface fdhc_sync_if;
   logic index_n;
   logic trk0_n;
   logic wprot_n;
   logic rdata_n;
   logic chg_n;
   modport src (output index_n, output trk0_n, output wprot_n, output rdata_n,
                output chg_n);
   modport dst (input index_n, input trk0_n, input wprot_n, input rdata_n,
                input chg_n);
endinterface // fdhc_sync_if
`default_nettype wire

// >>> design/fdhc_top.sv
// Host-side controller for a 3.5-inch floppy drive parallel interface.
// Assumes the drive pins are active low, open collector, pulled up outside.
// Function
// - Seek_sense stable across step trailing edge
// - One bit per record pulse
// - Swap flag cleared by stepping
// - No operation first 200 ms
// - Host recalibrates to track zero
// - Wait 700 or 500 ms spin-up
`timescale 1ns/10ps
`default_nettype none
module fdhc_top
   import fdhc_pkg::*;
#(
   parameter int unsigned POR_CYC   = POWERON_CYC,
   parameter int unsigned FRESH_CYC = SPIN_FRESH_CYC,
   parameter int unsigned KEPT_CYC  = SPIN_KEPT_CYC,
   parameter int unsigned RATE_CYC  = STEP_RATE_CYC,
   parameter int unsigned SET_CYC   = SETTLE_CYC
)(
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   input  wire logic        clk_en,
   // User side
   input  wire logic        cmd_select,
   input  wire logic        cmd_motor,
   input  wire logic        cmd_seek,
   input  wire logic        cmd_recal,
   input  wire logic [6:0]  cmd_track,
   input  wire logic        cmd_head,
   input  wire logic        cmd_wgate,
   input  wire logic        cmd_wbit,
   output logic             busy,
   output logic             ready,
   output logic [6:0]       cur_track,
   output logic             at_track0,
   output logic             wprotect,
   output logic             disk_changed,
   output logic             index_tick,
   output logic             rdata_tick,
   output logic             cmd_error,
   // Drive pins, active low
   output logic             unit_enable_n,
   output logic             spindle_run_request_n,
   output logic             track_advance_pulse_n,
   output logic             seek_sense_n,
   output logic             surface_choice_n,
   output logic             record_enable_n,
   output logic             record_pulse_n,
   input  wire logic        revolution_marker_n,
   input  wire logic        outer_cylinder_flag_n,
   input  wire logic        record_inhibit_flag_n,
   input  wire logic        playback_pulse_n,
   input  wire logic        media_swapped_flag_n
);
   // ----------------------------------------------------------------------
   // Reset release and input synchroniser
   // ----------------------------------------------------------------------
   logic       rst_meta;
   logic       rst_sync_n;
   fdhc_sync_if sif ();

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta   <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta   <= 1'b1;
         rst_sync_n <= rst_meta;
      end
   end

   fdhc_sync u_sync (
      .ref_clk (ref_clk),
      .rst_n   (rst_sync_n),
      .clk_en  (clk_en),
      .pins_n  ({media_swapped_flag_n, playback_pulse_n, record_inhibit_flag_n,
                 outer_cylinder_flag_n, revolution_marker_n}),
      .so      (sif.src)
   );

   // Counter load helper, saturating at one cycle minimum
   function automatic logic [CNT_W-1:0] cyc(input int unsigned n);
      cyc = (n == 0) ? CNT_W'(1) : CNT_W'(n);
   endfunction

   // ----------------------------------------------------------------------
   // State and registers
   // ----------------------------------------------------------------------
   fdhc_state_t      state,      next_state;
   logic [CNT_W-1:0] cnt,        next_cnt;
   logic [6:0]       trk,        next_trk;
   logic [6:0]       target,     next_target;
   logic             recal,      next_recal;
   logic             dir_out,    next_dir_out;
   logic             inserted,   next_inserted;  // Fresh insert pending
   logic             sel,        next_sel;
   logic             mot,        next_mot;
   logic             step_n,     next_step_n;
   logic             head_n,     next_head_n;
   logic             wg_n,       next_wg_n;
   logic             wd_n,       next_wd_n;
   logic [CNT_W-1:0] wcnt,       next_wcnt;
   logic             rdy,        next_rdy;
   logic             err,        next_err;
   logic             idx_d,      next_idx_d;
   logic             rd_d,       next_rd_d;
   logic             idx_t,      next_idx_t;
   logic             rd_t,       next_rd_t;
   logic             chg_d,      next_chg_d;
   logic             wp_r,       next_wp_r;
   logic             t0_r,       next_t0_r;
   logic             chg_r,      next_chg_r;

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      next_state    = state;
      next_cnt      = (cnt != '0) ? cnt - CNT_W'(1) : cnt;
      next_trk      = trk;
      next_target   = target;
      next_recal    = recal;
      next_dir_out  = dir_out;
      next_inserted = inserted;
      next_sel      = sel;
      next_mot      = mot;
      next_step_n   = step_n;
      next_head_n   = head_n;
      next_wg_n     = wg_n;
      next_wd_n     = wd_n;
      next_wcnt     = (wcnt != '0) ? wcnt - CNT_W'(1) : wcnt;
      next_rdy      = rdy;
      next_err      = 1'b0;
      // Edge pulses and selected levels from synchronised pins
      next_idx_d    = sif.index_n;
      next_rd_d     = sif.rdata_n;
      next_chg_d    = sif.chg_n;
      next_idx_t    = idx_d & ~sif.index_n & sel;
      next_rd_t     = rd_d & ~sif.rdata_n & sel;
      next_t0_r     = sel & ~sif.trk0_n;
      next_wp_r     = sel & ~sif.wprot_n;
      next_chg_r    = sel & ~sif.chg_n;

      case (state)
         FDHC_POR: begin
            if (cnt == '0)
               next_state = FDHC_IDLE;
         end
         FDHC_IDLE: begin
            next_sel = cmd_select;
            if (cmd_motor && !mot) begin
               next_mot   = 1'b1;
               next_rdy   = 1'b0;
               next_cnt   = inserted ? cyc(FRESH_CYC) : cyc(KEPT_CYC);
               next_state = FDHC_SPINUP;
            end else if (!cmd_motor && wg_n) begin
               next_mot = 1'b0;
               next_rdy = 1'b0;
            end
            if (wg_n)
               next_head_n = ~cmd_head;
            next_wg_n = ~(cmd_wgate & sel & sif.wprot_n & rdy);
            if (cmd_wbit && !wg_n && wcnt == '0) begin
               next_wd_n = 1'b0;
               next_wcnt = cyc(WDATA_LOW_CYC);
            end else if (wcnt == '0)
               next_wd_n = 1'b1;
            if (cmd_wgate && !sif.wprot_n && sel)
               next_err = 1'b1;
            if (sel && wg_n && cmd_recal) begin
               next_recal   = 1'b1;
               next_target  = 7'h00;
               next_dir_out = 1'b1;
               next_cnt     = cyc(DIR_SETUP_CYC);
               next_state   = FDHC_SETUP;
            end else if (sel && wg_n && cmd_seek) begin
               if (cmd_track >= 7'(MAX_TRACKS))
                  next_err = 1'b1;
               else if (cmd_track != trk || !sif.chg_n) begin
                  next_recal   = 1'b0;
                  next_target  = cmd_track;
                  next_dir_out = (cmd_track < trk) ||
                                 (cmd_track == trk && trk != 7'h00);
                  next_cnt     = cyc(DIR_SETUP_CYC);
                  next_state   = FDHC_SETUP;
               end
            end
         end
         FDHC_SETUP: begin
            if (cnt == '0) begin
               next_step_n = 1'b0;
               next_cnt    = cyc(STEP_LOW_CYC);
               next_state  = FDHC_PULSE;
            end
         end
         FDHC_PULSE: begin
            if (cnt == '0) begin
               next_step_n = 1'b1;
               if (dir_out)
                  next_trk = (trk != 7'h00) ? trk - 7'h01 : trk;
               else
                  next_trk = trk + 7'h01;
               next_inserted = next_inserted & ~sif.chg_n;
               next_cnt   = cyc(RATE_CYC);
               next_state = FDHC_GAP;
            end
         end
         FDHC_GAP: begin
            if (cnt == '0) begin
               if (recal && !sif.trk0_n) begin
                  next_trk   = 7'h00;
                  next_recal = 1'b0;
                  next_cnt   = cyc(SET_CYC);
                  next_state = FDHC_SETTLE;
               end else if (recal || trk != target) begin
                  next_cnt   = cyc(DIR_SETUP_CYC);
                  next_state = FDHC_SETUP;
               end else begin
                  next_cnt   = cyc(SET_CYC);
                  next_state = FDHC_SETTLE;
               end
            end
         end
         FDHC_SETTLE: begin
            if (cnt == '0)
               next_state = FDHC_IDLE;
         end
         FDHC_SPINUP: begin
            if (cnt == '0) begin
               next_rdy      = 1'b1;
               next_inserted = 1'b0;
               next_state    = FDHC_IDLE;
            end
         end
         default: next_state = FDHC_POR;
      endcase
      // Removal seen wins over any clear
      if (sel && chg_d && !sif.chg_n)
         next_inserted = 1'b1;
   end

   // ----------------------------------------------------------------------
   // Registers; all outputs below come straight from these
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         state    <= FDHC_POR;
         cnt      <= CNT_W'(POR_CYC);
         trk      <= 7'h00;
         target   <= 7'h00;
         recal    <= 1'b0;
         dir_out  <= 1'b1;
         inserted <= 1'b1;
         sel      <= 1'b0;
         mot      <= 1'b0;
         step_n   <= 1'b1;
         head_n   <= 1'b1;
         wg_n     <= 1'b1;
         wd_n     <= 1'b1;
         wcnt     <= '0;
         rdy      <= 1'b0;
         err      <= 1'b0;
         idx_d    <= 1'b1;
         rd_d     <= 1'b1;
         idx_t    <= 1'b0;
         rd_t     <= 1'b0;
         chg_d    <= 1'b1;
         wp_r     <= 1'b0;
         t0_r     <= 1'b0;
         chg_r    <= 1'b0;
      end else if (clk_en) begin
         state    <= next_state;
         cnt      <= next_cnt;
         trk      <= next_trk;
         target   <= next_target;
         recal    <= next_recal;
         dir_out  <= next_dir_out;
         inserted <= next_inserted;
         sel      <= next_sel;
         mot      <= next_mot;
         step_n   <= next_step_n;
         head_n   <= next_head_n;
         wg_n     <= next_wg_n;
         wd_n     <= next_wd_n;
         wcnt     <= next_wcnt;
         rdy      <= next_rdy;
         err      <= next_err;
         idx_d    <= next_idx_d;
         rd_d     <= next_rd_d;
         idx_t    <= next_idx_t;
         rd_t     <= next_rd_t;
         chg_d    <= next_chg_d;
         wp_r     <= next_wp_r;
         t0_r     <= next_t0_r;
         chg_r    <= next_chg_r;
      end
   end

   assign unit_enable_n         = ~sel;
   assign spindle_run_request_n = ~mot;
   assign track_advance_pulse_n = step_n;
   assign seek_sense_n          = dir_out;
   assign surface_choice_n      = head_n;
   assign record_enable_n       = wg_n;
   assign record_pulse_n        = wd_n;
   assign busy                  = ~state[1];
   assign ready                 = rdy;
   assign cur_track             = trk;
   assign at_track0             = t0_r;
   assign wprotect              = wp_r;
   assign disk_changed          = chg_r;
   assign index_tick            = idx_t;
   assign rdata_tick            = rd_t;
   assign cmd_error             = err;
endmodule // fdhc_top
`default_nettype wire

// >>> test/fdhc_drive_model.sv
// Behavioural drive at the far end of the host controller.
// Assumes open-collector outputs with pull-ups: a released line reads high.
`timescale 1ns/10ps
`default_nettype none
module fdhc_drive_model #(
   parameter int IDX_PER = 4000,
   parameter int IDX_LOW = 400,
   parameter int RD_PER  = 800
)(
   input  wire logic unit_enable_n,
   input  wire logic spindle_run_request_n,
   input  wire logic track_advance_pulse_n,
   input  wire logic seek_sense_n,
   input  wire logic surface_choice_n,
   input  wire logic record_enable_n,
   input  wire logic record_pulse_n,
   input  wire logic media_in,
   input  wire logic wp_media,
   output logic      revolution_marker_n,
   output logic      outer_cylinder_flag_n,
   output logic      record_inhibit_flag_n,
   output logic      playback_pulse_n,
   output logic      media_swapped_flag_n,
   output logic      lamp,
   output logic      head_used,
   output int        track,
   output int        bits_written
);
   logic sel;
   logic spin;
   logic idx_low = 1'b0;
   logic rd_low  = 1'b0;
   logic swapped = 1'b1;
   // --------------------------------------------------------------
   // Pins
   // --------------------------------------------------------------
   assign sel = !unit_enable_n;
   assign lamp = sel;
   assign spin = media_in && (!spindle_run_request_n || !record_enable_n);
   assign revolution_marker_n   = !(sel && idx_low);
   assign outer_cylinder_flag_n = !(sel && track == 0);
   assign record_inhibit_flag_n = !(sel && media_in && wp_media);
   assign playback_pulse_n      = !(sel && rd_low);
   assign media_swapped_flag_n  = !(sel && swapped);
   // Head starts off track zero so recalibration has work to do
   initial begin
      track = 5;
      bits_written = 0;
      head_used = 1'b0;
   end
   initial forever begin
      #(IDX_PER - IDX_LOW);
      idx_low = spin;
      #(IDX_LOW);
      idx_low = 1'b0;
   end
   initial forever begin
      #(RD_PER - 200);
      rd_low = spin && record_enable_n;
      #200;
      rd_low = 1'b0;
   end
   always @(posedge track_advance_pulse_n) begin
      if (sel) begin
         if (seek_sense_n)
            track = (track > 0) ? track - 1 : 0;
         else
            track = (track < 79) ? track + 1 : 79;
         if (media_in)
            swapped = 1'b1 == 1'b0;
      end
   end
   always @(negedge media_in) swapped = 1'b1;
   always @(negedge record_pulse_n) begin
      if (sel && !record_enable_n && !(media_in && wp_media))
         bits_written = bits_written + 1;
   end
   // head follows choice only with gate off
   always @* begin
      if (sel && record_enable_n)
         head_used = !surface_choice_n;
   end
endmodule // fdhc_drive_model
`default_nettype wire

// >>> test/fdhc_top_chk.sv
// Checker of drive pin timing for the floppy host controller.
// Assumes it is bound to fdhc_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module fdhc_top_chk
   import fdhc_pkg::*;
#(
   parameter int unsigned POR_CYC = 200
)(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic ready,
   input wire logic at_track0,
   input wire logic wprotect,
   input wire logic index_tick,
   input wire logic unit_enable_n,
   input wire logic spindle_run_request_n,
   input wire logic track_advance_pulse_n,
   input wire logic seek_sense_n,
   input wire logic record_enable_n,
   input wire logic record_pulse_n,
   input wire logic revolution_marker_n,
   input wire logic outer_cylinder_flag_n
);
   logic [31:0] por_cnt;
   logic [31:0] low_cnt;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // --------------------------------------------------------------
   // Helper counters
   // --------------------------------------------------------------
   // Cycles since reset, and cycles the step line has been low
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         por_cnt <= 32'h0;
         low_cnt <= 32'h0;
      end else begin
         if (clk_en && por_cnt < POR_CYC)
            por_cnt <= por_cnt + 32'h1;
         low_cnt <= track_advance_pulse_n ? 32'h0 : low_cnt + 32'h1;
      end
   end
   sequence s_step_end;
      $rose(track_advance_pulse_n);
   endsequence
   sequence s_gate_open;
      $fell(record_enable_n);
   endsequence
   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   seek_dir_hold_a: assert property (!track_advance_pulse_n |=> $stable(seek_sense_n))
      else $error("direction moved during a step");
   step_width_a: assert property (s_step_end |-> low_cnt == STEP_LOW_CYC + 1)
      else $error("step pulse has the wrong width");
   rec_in_gate_a: assert property (!record_pulse_n |-> !record_enable_n)
      else $error("record pulse outside the gate");
   por_quiet_a: assert property (por_cnt < POR_CYC |-> unit_enable_n &&
      spindle_run_request_n && track_advance_pulse_n && record_enable_n)
      else $error("drive touched during power-on wait");
   gate_ready_a: assert property (s_gate_open |-> ready && !wprotect && !unit_enable_n)
      else $error("gate opened when not allowed");
   motor_hold_a: assert property ($rose(spindle_run_request_n) |-> record_enable_n)
      else $error("spindle released while gate on");
   track0_sync_a: assert property ($fell(outer_cylinder_flag_n) && !unit_enable_n
      |-> ##[2:4] at_track0)
      else $error("track zero flag not passed on");
   index_sync_a: assert property ($fell(revolution_marker_n) && !unit_enable_n
      |-> ##[2:4] index_tick)
      else $error("revolution marker not passed on");
   no_out_zero_a: assert property ($fell(track_advance_pulse_n) && at_track0
      |-> !seek_sense_n)
      else $error("outward step from track zero");
endmodule // fdhc_top_chk
bind fdhc_top fdhc_top_chk #(.POR_CYC(POR_CYC)) i_chk (
   .ref_clk, .rst_n, .clk_en, .ready, .at_track0, .wprotect, .index_tick,
   .unit_enable_n, .spindle_run_request_n, .track_advance_pulse_n, .seek_sense_n,
   .record_enable_n, .record_pulse_n, .revolution_marker_n, .outer_cylinder_flag_n
);
`default_nettype wire

// >>> test/fdhc_top_tb.sv
// Self-checking bench for the floppy host controller and a drive model.
// Assumes shortened wait parameters; all expectations derive from them.
`timescale 1ns/10ps
`default_nettype none
module fdhc_top_tb;
   import fdhc_pkg::*;
   localparam int POR = 200;
   logic ref_clk = 1'b0, rst_n = 1'b0, media_in = 1'b1, wp_media = 1'b0;
   logic cmd_select = 1'b0, cmd_motor = 1'b0, cmd_seek = 1'b0, cmd_recal = 1'b0;
   logic cmd_head = 1'b0, cmd_wgate = 1'b0, cmd_wbit = 1'b0;
   logic [6:0] cmd_track = 7'h00;
   logic [6:0] cur_track;
   logic busy, ready, at_track0, wprotect, disk_changed, index_tick, rdata_tick, cmd_error;
   logic unit_enable_n, spindle_run_request_n, track_advance_pulse_n, seek_sense_n;
   logic surface_choice_n, record_enable_n, record_pulse_n, revolution_marker_n;
   logic outer_cylinder_flag_n, record_inhibit_flag_n, playback_pulse_n, media_swapped_flag_n;
   logic lamp, head_used, err_seen, idx_seen, rd_seen;
   int   track, bits_written, error_cnt = 0, check_count = 0;
   fdhc_top #(.POR_CYC(POR), .FRESH_CYC(300), .KEPT_CYC(200), .RATE_CYC(50), .SET_CYC(50)) i_dut (
      .ref_clk, .rst_n, .clk_en(1'b1), .cmd_select, .cmd_motor, .cmd_seek, .cmd_recal,
      .cmd_track, .cmd_head, .cmd_wgate, .cmd_wbit, .busy, .ready, .cur_track, .at_track0,
      .wprotect, .disk_changed, .index_tick, .rdata_tick, .cmd_error, .unit_enable_n,
      .spindle_run_request_n, .track_advance_pulse_n, .seek_sense_n, .surface_choice_n,
      .record_enable_n, .record_pulse_n, .revolution_marker_n, .outer_cylinder_flag_n,
      .record_inhibit_flag_n, .playback_pulse_n, .media_swapped_flag_n);
   fdhc_drive_model i_drive (
      .unit_enable_n, .spindle_run_request_n, .track_advance_pulse_n, .seek_sense_n,
      .surface_choice_n, .record_enable_n, .record_pulse_n, .media_in, .wp_media,
      .revolution_marker_n, .outer_cylinder_flag_n, .record_inhibit_flag_n,
      .playback_pulse_n, .media_swapped_flag_n, .lamp, .head_used, .track, .bits_written);
   // --------------------------------------------------------------
   // Clock, pulse catcher and shared tasks
   // --------------------------------------------------------------
   initial forever #4 ref_clk = ~ref_clk;
   // One-cycle pulses are caught here so a task can judge them later
   always @(posedge ref_clk) begin
      if (cmd_error === 1'b1) err_seen <= 1'b1;
      if (index_tick === 1'b1) idx_seen <= 1'b1;
      if (rdata_tick === 1'b1) rd_seen <= 1'b1;
   end
   task automatic close_out();
      if (error_cnt == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected %s: expected %0h, seen %0h", name, exp, got);
      end
   endtask
   // Bounded wait; running out ends the run as a failure
   task automatic wait_for(input int lim, ref logic sig, input logic val);
      for (int i = 0; i <= lim; i++) begin
         if (sig === val)
            return;
         @(negedge ref_clk);
      end
      chk("wait_level", {31'h0, val}, {31'h0, sig});
      close_out();
   endtask
   task automatic pulse(ref logic sig);
      sig = 1'b1;
      @(negedge ref_clk);
      sig = 1'b0;
      @(negedge ref_clk);
   endtask
   task automatic t_seek(input logic [6:0] trk, input logic [6:0] exp, input logic e);
      cmd_track = trk;
      err_seen = 1'b0;
      pulse(cmd_seek);
      wait_for(40000, busy, 1'b0);
      chk("cmd_error", {31'h0, e}, {31'h0, err_seen});
      chk("drive_track", {25'h0, exp}, track);
      chk("cur_track", {25'h0, exp}, {25'h0, cur_track});
   endtask
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic t_recal();
      cmd_select = 1'b1;
      @(negedge ref_clk);
      pulse(cmd_recal);
      wait_for(40000, busy, 1'b0);
      chk("lamp", 32'h1, {31'h0, lamp});
      chk("drive_track", 32'h0, track);
      chk("at_track0", 32'h1, {31'h0, at_track0});
      chk("disk_changed", 32'h0, {31'h0, disk_changed});
   endtask
   task automatic t_spin();
      cmd_motor = 1'b1;
      wait_for(2000, ready, 1'b1);
      chk("spindle_req_n", 32'h0, {31'h0, spindle_run_request_n});
      idx_seen = 1'b0;
      rd_seen = 1'b0;
      wait_for(1000, idx_seen, 1'b1);
      repeat (110) @(negedge ref_clk);
      chk("rdata_tick", 32'h1, {31'h0, rd_seen});
   endtask
   task automatic t_write();
      cmd_head = 1'b1;
      @(negedge ref_clk);
      chk("head_used", 32'h1, {31'h0, head_used});
      cmd_wgate = 1'b1;
      wait_for(100, record_enable_n, 1'b0);
      cmd_head = 1'b0;
      cmd_motor = 1'b0;
      repeat (4) begin
         pulse(cmd_wbit);
         wait_for(20, record_pulse_n, 1'b0);
         wait_for(100, record_pulse_n, 1'b1);
      end
      chk("bits_written", 32'h4, bits_written);
      chk("surface_choice_n", 32'h0, {31'h0, surface_choice_n});
      chk("spindle_req_n", 32'h0, {31'h0, spindle_run_request_n});
      cmd_wgate = 1'b0;
      wait_for(100, spindle_run_request_n, 1'b1);
      wait_for(100, surface_choice_n, 1'b1);
      chk("head_used", 32'h0, {31'h0, head_used});
      pulse(cmd_wbit);
      chk("bits_written", 32'h4, bits_written);
   endtask
   task automatic t_protect();
      cmd_motor = 1'b1;
      wait_for(2000, ready, 1'b1);
      wp_media = 1'b1;
      wait_for(20, wprotect, 1'b1);
      err_seen = 1'b0;
      pulse(cmd_wgate);
      wait_for(20, err_seen, 1'b1);
      chk("record_enable_n", 32'h1, {31'h0, record_enable_n});
      wp_media = 1'b0;
   endtask
   task automatic t_change();
      media_in = 1'b0;
      wait_for(20, disk_changed, 1'b1);
      t_seek(7'h01, 7'h01, 1'b0);
      chk("disk_changed", 32'h1, {31'h0, disk_changed});
      media_in = 1'b1;
      t_seek(7'h02, 7'h02, 1'b0);
      chk("disk_changed", 32'h0, {31'h0, disk_changed});
   endtask
   task automatic t_deselect();
      cmd_select = 1'b0;
      wait_for(20, unit_enable_n, 1'b1);
      chk("lamp", 32'h0, {31'h0, lamp});
      t_seek(7'h05, 7'h02, 1'b0);
   endtask
   initial begin
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      wait_for(4 * POR, busy, 1'b0);
      t_recal();
      t_seek(7'h03, 7'h03, 1'b0);
      t_seek(7'h4f, 7'h4f, 1'b0);
      t_seek(7'h50, 7'h4f, 1'b1);
      t_seek(7'h02, 7'h02, 1'b0);
      t_spin();
      t_write();
      t_protect();
      t_change();
      t_deselect();
      close_out();
   end
endmodule // fdhc_top_tb
`default_nettype wire
